// ===== adc_seq_params.svh
// Register offsets, field positions, reset values and timing counts of the converter sequencer.
// Summary of operation
// - Port read of analog pins returns zero.
// - Conversion ignores analog select and direction bits.
// - Analog select kills input buffer; direction kills driver.
// - Channel select field routes sample-and-hold input.
// - Two-bit positive and negative reference selects.
// - Acquisition field offers 2 to 20 periods.
// - Programmed mode samples, then converts automatically.
// - Field value zero selects manual acquisition.
// - Manual mode: go stops sampling, converts at once.
// - Acquisition field resets to zero.
// - Completion clears go and sets complete flag.
// - After completion, resume sampling selected channel.
// - No status separates acquisition from conversion.
// - Strap sets second port analog select reset value.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define OFS_CTRL0        12'h000
`define OFS_CTRL1        12'h004
`define OFS_CTRL2        12'h008
`define OFS_ANSEL_A      12'h00C
`define OFS_ANSEL_B      12'h010
`define OFS_DIR          12'h014
`define OFS_LAT          12'h018
`define OFS_PORT         12'h01C
`define OFS_IRQ_STATUS   12'h020
`define OFS_IRQ_ENABLE   12'h024
`define OFS_IRQ_CLEAR    12'h028
`define CTRL0_GO_BIT     1
`define CTRL0_ON_BIT     0
`define CTRL0_CHS_LSB    2
`define CTRL1_NREF_LSB   0
`define CTRL1_PREF_LSB   2
`define CTRL2_ACQ_LSB    3
`define CTRL2_CLKDIV_LSB 0
`define ACQ_RESET        3'h0
`define CTRL2_RESET      32'h00000000
`define IRQ_DONE_BIT     0
`define CONV_PERIODS     11
`endif

// ===== adc_seq_pkg.sv
// Types shared by the converter sequencer.
package adc_seq_pkg;
    typedef enum logic [1:0] {
        ST_SAMPLE  = 2'b00,
        ST_ACQUIRE = 2'b01,
        ST_CONVERT = 2'b10
    } seq_state_t;
    typedef enum logic [1:0] {
        PREF_SUPPLY = 2'b00,
        PREF_EXT    = 2'b01,
        PREF_FIXED  = 2'b10
    } pref_t;
endpackage : adc_seq_pkg

// ===== tad_tick.sv
// Divider that makes one pulse per conversion clock period.
`timescale 1ns/1ps
module tad_tick #(
    parameter int DIV_W = 3
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] div_sel,
    output logic                  tick
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] limit;

    // The limit below is eight bits wide, so a select wider than three bits cannot be served.
    if (DIV_W < 1 || DIV_W > 3) begin : g_bad_div_w
        $error("tad_tick: DIV_W must be 1 to 3");
    end

    always_comb begin
        limit = 8'(((1 << div_sel) * 2) - 1);
        cnt_next = cnt_reg;
        tick = 1'b0;
        if (!run) begin
            cnt_next = 8'h00;
        end else if (cnt_reg >= limit) begin
            cnt_next = 8'h00;
            tick = 1'b1;
        end else begin
            cnt_next = cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : tad_tick

// ===== adc_acquire_convert_sequencer.sv
// Converter sequencer with AXI4-Lite registers, pin gating and completion interrupt.
`timescale 1ns/1ps
`include "adc_seq_params.svh"
module adc_acquire_convert_sequencer #(
    parameter int PINS      = 8,
    parameter int CHS_W     = 5,
    parameter int CONV_TADS = `CONV_PERIODS
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [11:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [11:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             second_port_analog_reset_cfg,
    input  wire logic [PINS-1:0]  pin_in,
    output logic [PINS-1:0]       pin_out,
    output logic [PINS-1:0]       pin_oe_n,
    output logic [PINS-1:0]       input_buffer_en,
    output logic [PINS-1:0]       second_pin_input_buffer_en,
    output logic [CHS_W-1:0]      sample_channel,
    output logic                  sample_enable,
    output logic                  convert_start,
    input  wire logic             convert_done,
    output logic [1:0]            positive_ref_select,
    output logic [1:0]            negative_ref_select,
    output logic                  irq
);
    if (PINS < 1 || PINS > 32) begin : g_bad_pins
        $error("PINS must be 1 to 32");
    end
    if (CHS_W < 1 || CHS_W > 5) begin : g_bad_chs_w
        $error("CHS_W must be 1 to 5");
    end
    if (CONV_TADS < 1 || CONV_TADS > 31) begin : g_bad_conv_tads
        $error("CONV_TADS must be 1 to 31");
    end

    // Registers.
    logic             on_reg, on_next, go_reg, go_next;
    logic [CHS_W-1:0] chs_reg, chs_next;
    logic [1:0]       pref_reg, pref_next, nref_reg, nref_next;
    logic [2:0]       acq_reg, acq_next, div_reg, div_next;
    logic [PINS-1:0]  ansa_reg, ansa_next, ansb_reg, ansb_next, dir_reg, dir_next, lat_reg, lat_next;
    logic             irq_st_reg, irq_st_next, irq_en_reg, irq_en_next;
    logic             strap_seen_reg, strap_seen_next;
    logic             bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [31:0]      rdata_reg, rdata_next;
    logic [1:0]       bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic             aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [11:0]      awaddr_reg, awaddr_next;
    logic [31:0]      wdata_reg, wdata_next;
    logic [PINS-1:0]  pin_s1_reg, pin_s2_reg;
    logic             done_s1_reg, done_s2_reg, done_d_reg;
    adc_seq_pkg::seq_state_t st_reg, st_next;
    logic [4:0]       tcnt_reg, tcnt_next;
    logic             start_reg, start_next;

    logic        tick, done_rise, aw_ok, w_ok, wr_fire, finish;
    logic [11:0] wa;
    logic [31:0] wd;
    logic [4:0]  acq_tads;

    tad_tick #(.DIV_W(3)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (st_reg != adc_seq_pkg::ST_SAMPLE),
        .div_sel (div_reg),
        .tick    (tick)
    );

    // Pin samples pass two flops before anything reads them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg  <= '0;
            pin_s2_reg  <= '0;
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_d_reg  <= 1'b0;
        end else begin
            pin_s1_reg  <= pin_in;
            pin_s2_reg  <= pin_s1_reg;
            done_s1_reg <= convert_done;
            done_s2_reg <= done_s1_reg;
            done_d_reg  <= done_s2_reg;
        end
    end
    assign done_rise = done_s2_reg & ~done_d_reg;

    // Programmed codes 1..7 map to 2,4,6,8,12,16,20 periods.
    always_comb begin
        unique case (acq_reg)
            3'h1: acq_tads = 5'h02;
            3'h2: acq_tads = 5'h04;
            3'h3: acq_tads = 5'h06;
            3'h4: acq_tads = 5'h08;
            3'h5: acq_tads = 5'h0C;
            3'h6: acq_tads = 5'h10;
            3'h7: acq_tads = 5'h14;
            3'h0: acq_tads = 5'h00;
        endcase
    end

    // Write channel: address and data may arrive in either order.
    assign aw_ok   = aw_held_reg | s_axi_awvalid;
    assign w_ok    = w_held_reg | s_axi_wvalid;
    assign wr_fire = aw_ok & w_ok & ~bvalid_reg;
    assign wa      = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    assign wd      = w_held_reg ? wdata_reg : s_axi_wdata;
    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;

    // Sequencer.
    always_comb begin
        st_next    = st_reg;
        tcnt_next  = tcnt_reg;
        start_next = 1'b0;
        finish     = 1'b0;
        unique case (st_reg)
            adc_seq_pkg::ST_SAMPLE: begin
                if (go_reg && on_reg) begin
                    if (acq_reg == `ACQ_RESET) begin
                        st_next    = adc_seq_pkg::ST_CONVERT;
                        start_next = 1'b1;
                        tcnt_next  = 5'(CONV_TADS);
                    end else begin
                        st_next   = adc_seq_pkg::ST_ACQUIRE;
                        tcnt_next = acq_tads;
                    end
                end
            end
            adc_seq_pkg::ST_ACQUIRE: begin
                if (tick) begin
                    if (tcnt_reg <= 5'h01) begin
                        st_next    = adc_seq_pkg::ST_CONVERT;
                        start_next = 1'b1;
                        tcnt_next  = 5'(CONV_TADS);
                    end else begin
                        tcnt_next = tcnt_reg - 5'h01;
                    end
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                if (done_rise || (tick && tcnt_reg <= 5'h01)) begin
                    st_next = adc_seq_pkg::ST_SAMPLE;
                    finish  = 1'b1;
                end else if (tick) begin
                    tcnt_next = tcnt_reg - 5'h01;
                end
            end
            default: st_next = adc_seq_pkg::ST_SAMPLE;
        endcase
        // Switching off mid-acquisition must not leave a start pulse for the core.
        if (!on_reg) begin
            st_next    = adc_seq_pkg::ST_SAMPLE;
            start_next = 1'b0;
        end
    end

    // Register file next state.
    always_comb begin
        on_next = on_reg; go_next = go_reg; chs_next = chs_reg;
        pref_next = pref_reg; nref_next = nref_reg; acq_next = acq_reg; div_next = div_reg;
        ansa_next = ansa_reg; ansb_next = ansb_reg; dir_next = dir_reg; lat_next = lat_reg;
        irq_en_next = irq_en_reg; irq_st_next = irq_st_reg;
        strap_seen_next = 1'b1;
        aw_held_next = aw_held_reg; w_held_next = w_held_reg;
        awaddr_next = awaddr_reg; wdata_next = wdata_reg;
        bvalid_next = bvalid_reg; bresp_next = bresp_reg;
        rvalid_next = rvalid_reg; rdata_next = rdata_reg; rresp_next = rresp_reg;
        if (!strap_seen_reg) begin
            ansb_next = {PINS{second_port_analog_reset_cfg}};
        end
        if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata;
        end
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = 2'b00;
            unique case ({2'b00, wa[11:2]})
                `OFS_CTRL0 >> 2: begin
                    on_next  = wd[`CTRL0_ON_BIT];
                    go_next  = wd[`CTRL0_GO_BIT] | go_reg;
                    chs_next = wd[`CTRL0_CHS_LSB +: CHS_W];
                end
                `OFS_CTRL1 >> 2: begin
                    nref_next = wd[`CTRL1_NREF_LSB +: 2];
                    pref_next = wd[`CTRL1_PREF_LSB +: 2];
                end
                `OFS_CTRL2 >> 2: begin
                    acq_next = wd[`CTRL2_ACQ_LSB +: 3];
                    div_next = wd[`CTRL2_CLKDIV_LSB +: 3];
                end
                `OFS_ANSEL_A >> 2:   ansa_next = wd[PINS-1:0];
                `OFS_ANSEL_B >> 2:   ansb_next = wd[PINS-1:0];
                `OFS_DIR >> 2:       dir_next = wd[PINS-1:0];
                `OFS_LAT >> 2:       lat_next = wd[PINS-1:0];
                `OFS_IRQ_ENABLE >> 2: irq_en_next = wd[`IRQ_DONE_BIT];
                `OFS_IRQ_CLEAR >> 2: begin
                    if (wd[`IRQ_DONE_BIT]) irq_st_next = 1'b0;
                end
                `OFS_PORT >> 2, `OFS_IRQ_STATUS >> 2: bresp_next = 2'b00;
                default: bresp_next = 2'b10;
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // Completion wins over a software clear in the same cycle.
        if (finish) begin
            go_next     = 1'b0;
            irq_st_next = 1'b1;
        end
        if (!on_reg) begin
            go_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = 2'b00;
            rdata_next  = 32'h00000000;
            unique case ({2'b00, s_axi_araddr[11:2]})
                `OFS_CTRL0 >> 2: begin
                    rdata_next[`CTRL0_ON_BIT] = on_reg;
                    rdata_next[`CTRL0_GO_BIT] = go_reg;
                    rdata_next[`CTRL0_CHS_LSB +: CHS_W] = chs_reg;
                end
                `OFS_CTRL1 >> 2: begin
                    rdata_next[`CTRL1_NREF_LSB +: 2] = nref_reg;
                    rdata_next[`CTRL1_PREF_LSB +: 2] = pref_reg;
                end
                `OFS_CTRL2 >> 2: begin
                    rdata_next[`CTRL2_ACQ_LSB +: 3]    = acq_reg;
                    rdata_next[`CTRL2_CLKDIV_LSB +: 3] = div_reg;
                end
                `OFS_ANSEL_A >> 2:    rdata_next[PINS-1:0] = ansa_reg;
                `OFS_ANSEL_B >> 2:    rdata_next[PINS-1:0] = ansb_reg;
                `OFS_DIR >> 2:        rdata_next[PINS-1:0] = dir_reg;
                `OFS_LAT >> 2:        rdata_next[PINS-1:0] = lat_reg;
                `OFS_PORT >> 2:       rdata_next[PINS-1:0] = pin_s2_reg & ~ansa_reg;
                `OFS_IRQ_STATUS >> 2: rdata_next[`IRQ_DONE_BIT] = irq_st_reg;
                `OFS_IRQ_ENABLE >> 2: rdata_next[`IRQ_DONE_BIT] = irq_en_reg;
                `OFS_IRQ_CLEAR >> 2:  rdata_next = 32'h00000000;
                default:              rresp_next = 2'b10;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_reg <= 1'b0; go_reg <= 1'b0; chs_reg <= '0;
            pref_reg <= 2'h0; nref_reg <= 2'h0;
            acq_reg <= `ACQ_RESET;
            div_reg <= 3'h0;
            ansa_reg <= '1; ansb_reg <= '1; dir_reg <= '1; lat_reg <= '0;
            irq_st_reg <= 1'b0; irq_en_reg <= 1'b0; strap_seen_reg <= 1'b0;
            aw_held_reg <= 1'b0; w_held_reg <= 1'b0; awaddr_reg <= 12'h000; wdata_reg <= 32'h00000000;
            bvalid_reg <= 1'b0; bresp_reg <= 2'b00; rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000; rresp_reg <= 2'b00;
            st_reg <= adc_seq_pkg::ST_SAMPLE; tcnt_reg <= 5'h00; start_reg <= 1'b0;
        end else begin
            on_reg <= on_next; go_reg <= go_next; chs_reg <= chs_next;
            pref_reg <= pref_next; nref_reg <= nref_next; acq_reg <= acq_next; div_reg <= div_next;
            ansa_reg <= ansa_next; ansb_reg <= ansb_next; dir_reg <= dir_next; lat_reg <= lat_next;
            irq_st_reg <= irq_st_next; irq_en_reg <= irq_en_next; strap_seen_reg <= strap_seen_next;
            aw_held_reg <= aw_held_next; w_held_reg <= w_held_next;
            awaddr_reg <= awaddr_next; wdata_reg <= wdata_next;
            bvalid_reg <= bvalid_next; bresp_reg <= bresp_next; rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next; rresp_reg <= rresp_next;
            st_reg <= st_next; tcnt_reg <= tcnt_next; start_reg <= start_next;
        end
    end

    // The converter path never looks at select or direction bits, so a digital pin converts too.
    assign sample_channel      = chs_reg;
    assign sample_enable       = on_reg && (st_reg != adc_seq_pkg::ST_CONVERT);
    assign convert_start       = start_reg;
    assign positive_ref_select = pref_reg;
    assign negative_ref_select = nref_reg;
    assign input_buffer_en            = ~ansa_reg;
    assign second_pin_input_buffer_en = ~ansb_reg;
    assign pin_oe_n = dir_reg;
    assign pin_out  = lat_reg;
    assign irq      = irq_st_reg & irq_en_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;
endmodule : adc_acquire_convert_sequencer

// ===== adc_seq_checker.sv
// Port-level concurrent checks for the converter sequencer.
`timescale 1ns/1ps
module adc_seq_checker #(
    parameter int CONV_TADS = 11
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sample_enable,
    input wire logic convert_start,
    input wire logic convert_done,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence seq_sampling_stops;
        $fell(sample_enable);
    endsequence
    sequence seq_conv_end;
        !sample_enable && $rose(convert_done);
    endsequence
    AST_START_NOT_SAMPLING: assert property (convert_start |-> !sample_enable)
        else $error("conversion started while sampling");
    AST_START_ONE_CYCLE: assert property (convert_start |=> !convert_start)
        else $error("start pulse longer than one cycle");
    AST_STOP_THEN_START: assert property (seq_sampling_stops |-> ##[0:2] convert_start)
        else $error("sampling stopped without a conversion start");
    AST_HOLD_WHILE_CONVERTING: assert property (convert_start |=> !sample_enable [*2])
        else $error("sampling resumed during conversion");
    AST_RESUME_AFTER_DONE: assert property (seq_conv_end |-> ##[1:6] sample_enable)
        else $error("sampling did not resume after completion");
    // The interrupt may only rise on a completion or just after a register write.
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> !$past(sample_enable) || !$past(sample_enable, 2)
        || s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("interrupt rose without cause");
    AST_BVALID_DROPS: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_RVALID_DROPS: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule : adc_seq_checker

bind adc_acquire_convert_sequencer adc_seq_checker #(.CONV_TADS(CONV_TADS)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_enable(sample_enable),
    .convert_start(convert_start), .convert_done(convert_done), .irq(irq));

// ===== conv_core_model.sv
// Behavioural converter core that answers each start with a done pulse.
`timescale 1ns/1ps
module conv_core_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic slow,
    input  wire logic convert_start,
    output logic      convert_done
);
    int cnt_reg;
    // The slow answer stays inside the sequencer's own conversion timeout.
    always_ff @(posedge aclk) begin
        if (!aresetn || convert_start) begin
            cnt_reg <= !aresetn ? 0 : (slow ? 15 : 3);
            convert_done <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg > 0) ? cnt_reg - 1 : 0;
            convert_done <= (cnt_reg == 1);
        end
    end
endmodule : conv_core_model

// ===== tb_top.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
`include "adc_seq_params.svh"
`define CHK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("mismatch at %0t: %h vs %h", $time, g, e); \
    end \
end
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, strap = 1'b1, slow = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [7:0] pin_in = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, samp, cstart, cdone, irq;
    logic [1:0] bresp, rresp, pref, nref, bexp;
    logic [31:0] rdata;
    logic [7:0] pin_out, pin_oe_n, ibuf, ibuf2, an, dr;
    logic [4:0] chan, ch;
    logic [33:0] rexp;
    logic [8:0] cexp;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [8:0] cv_q[$];
    logic [15:0] rnd = 16'h7A5B;
    int fail_count = 0, n_tests = 0, cnt, per[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    always #20 aclk = ~aclk;

    adc_acquire_convert_sequencer #(.PINS(8), .CHS_W(5), .CONV_TADS(16)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .second_port_analog_reset_cfg(strap), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .input_buffer_en(ibuf), .second_pin_input_buffer_en(ibuf2), .sample_channel(chan),
        .sample_enable(samp), .convert_start(cstart), .convert_done(cdone),
        .positive_ref_select(pref), .negative_ref_select(nref), .irq(irq));

    conv_core_model i_core (.aclk(aclk), .aresetn(aresetn), .slow(slow), .convert_start(cstart),
        .convert_done(cdone));

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        wr_q.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        rd_q.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask : axi_rd

    task automatic irq_is(input logic v);
        repeat (2) @(posedge aclk);
        `CHK(irq, v)
    endtask : irq_is

    // Results are compared in arrival order against the notes left by the drivers.
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            rexp = rd_q.pop_front();
            if (rexp[33]) `CHK(rresp, rexp[33:32]) else `CHK({rresp, rdata}, rexp)
        end
        if (bvalid && bready) begin
            bexp = wr_q.pop_front();
            `CHK(bresp, bexp)
        end
        if (cstart) begin
            cexp = cv_q.pop_front();
            `CHK({chan, pref, nref}, cexp)
        end
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        give_verdict();
    end

    initial begin
        for (int s = 0; s < 2; s++) begin
            @(posedge aclk);
            aresetn <= 1'b0;
            strap <= s[0];
            repeat (8) @(posedge aclk);
            aresetn <= 1'b1;
            axi_rd(`OFS_CTRL2, 32'h00000000, 2'b00);
            axi_rd(`OFS_ANSEL_B, {24'h000000, {8{s[0]}}}, 2'b00);
            `CHK({ibuf2, ibuf, pin_oe_n}, {{8{~s[0]}}, 8'h00, 8'hFF})
        end
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(lfsr(rnd));
            an = rnd[7:0];
            dr = rnd[15:8];
            axi_wr(`OFS_ANSEL_A, {24'h000000, an}, 2'b00);
            axi_wr(`OFS_DIR, {24'h000000, dr}, 2'b00);
            rnd = lfsr(lfsr(rnd));
            axi_wr(`OFS_LAT, {24'h000000, rnd[7:0]}, 2'b00);
            pin_in <= rnd[15:8];
            repeat (4) @(posedge aclk);
            axi_rd(`OFS_PORT, {24'h000000, rnd[15:8] & ~an}, 2'b00);
            `CHK({pin_oe_n, ibuf, pin_out}, {dr, ~an, rnd[7:0]})
        end
        axi_rd(12'h02C, 32'h00000000, 2'b10);
        axi_wr(12'h030, 32'h00000001, 2'b10);
        axi_wr(`OFS_IRQ_ENABLE, 32'h00000001, 2'b00);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            ch = rnd[4:0];
            slow <= k[0];
            axi_wr(`OFS_CTRL1, {28'h0000000, 2'(k % 3), 1'b0, k[1]}, 2'b00);
            // The divider field walks through four settings, so the tick period is 2 << k[1:0] cycles.
            axi_wr(`OFS_CTRL2, {26'h0000000, k[2:0], 1'b0, k[1:0]}, 2'b00);
            axi_wr(`OFS_CTRL0, {25'h0000000, ch, 2'b01}, 2'b00);
            repeat (10) @(posedge aclk);
            cv_q.push_back({ch, 2'(k % 3), 1'b0, k[1]});
            axi_wr(`OFS_CTRL0, {25'h0000000, ch, 2'b11}, 2'b00);
            cnt = 0;
            while (!cstart) begin
                @(posedge aclk);
                cnt++;
            end
            `CHK(cnt >= (2 << k[1:0]) * per[k] - 2 && cnt <= (2 << k[1:0]) * per[k] + 4, 1'b1)
            if (k[0]) axi_rd(`OFS_CTRL0, {25'h0000000, ch, 2'b11}, 2'b00);
            while (!irq) @(posedge aclk);
            `CHK(samp, 1'b1)
            axi_rd(`OFS_CTRL0, {25'h0000000, ch, 2'b01}, 2'b00);
            axi_rd(`OFS_IRQ_STATUS, 32'h00000001, 2'b00);
            axi_wr(`OFS_IRQ_ENABLE, 32'h00000000, 2'b00);
            irq_is(1'b0);
            axi_wr(`OFS_IRQ_ENABLE, 32'h00000001, 2'b00);
            irq_is(1'b1);
            axi_wr(`OFS_IRQ_CLEAR, 32'h00000001, 2'b00);
            irq_is(1'b0);
        end
        give_verdict();
    end
endmodule : tb_top
